// ---- logic/lomc_regs.vh ----
// register map, field positions, reset values and timing for the line output mixer bank
`ifndef LOMC_REGS_VH
`define LOMC_REGS_VH

// register offsets, page 0
`define LOMC_MONO_LINE2_LEFT 8'h49
`define LOMC_MONO_PGA_LEFT 8'h4a
`define LOMC_MONO_DAC_LEFT_ONE 8'h4b
`define LOMC_MONO_LINE2_RIGHT 8'h4c
`define LOMC_MONO_PGA_RIGHT 8'h4d
`define LOMC_MONO_DAC_RIGHT_ONE 8'h4e
`define LOMC_MONO_LEVEL 8'h4f
`define LOMC_LEFT_LINE2_LEFT 8'h50
`define LOMC_LEFT_PGA_LEFT 8'h51
`define LOMC_LEFT_DAC_LEFT_ONE 8'h52
`define LOMC_LEFT_LINE2_RIGHT 8'h53
`define LOMC_LEFT_PGA_RIGHT 8'h54
`define LOMC_LEFT_DAC_RIGHT_ONE 8'h55
`define LOMC_LEFT_LEVEL 8'h56

// route register fields
`define LOMC_ROUTE_EN_BIT 7
`define LOMC_VOL_MSB 6
`define LOMC_VOL_LSB 0

// level register fields
`define LOMC_LEVEL_MSB 7
`define LOMC_LEVEL_LSB 4
`define LOMC_UNMUTE_BIT 3
`define LOMC_RSVD_BIT 2
`define LOMC_PEND_BIT 1
`define LOMC_PWR_BIT 0

// reset values and the no-route index
`define LOMC_VOL_RST 7'h00
`define LOMC_LEVEL_RST 4'h0
`define LOMC_ROUTE_NONE 4'hf

// gain stepping interval
`define LOMC_STEP_NS 1000
`define LOMC_CLK_MHZ 250
`define LOMC_STEP_CYCLES ((`LOMC_STEP_NS * `LOMC_CLK_MHZ) / 1000)

`endif

// ---- logic/lomc_line_out_regs.v ----
// register bank for the mono and left line output mixers
// Notes on behaviour
// - bit 7 connects source into mixer, resets 0
// - bits 6..0 hold 7-bit route volume, reset 0
// - mono routes at 74 to 78
// - left routes at 80 to 85, same layout
// - level bits 7..4, 1 dB steps, reset 0
// - bit 3 low mutes, muted after reset
// - bit 1 reads 1 while gains not applied
// - bit 0 requests full power-up, reset 0
// - sixth mono route sits at 73
`include "lomc_regs.vh"
`default_nettype none

module lomc_line_out_regs #(
  parameter integer STEP_CYCLES = `LOMC_STEP_CYCLES
) (
  // clock and reset
  input wire sys_clk_in,
  input wire rst_n_in,
  // register port
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  // mono line output controls
  output wire [5:0] mono_route_en_out,
  output wire [41:0] mono_route_vol_out,
  output wire [3:0] mono_level_out,
  output wire mono_unmute_out,
  output wire mono_power_up_out,
  output wire mono_gain_pending_out,
  // left line output controls
  output wire [5:0] left_route_en_out,
  output wire [41:0] left_route_vol_out,
  output wire [3:0] left_level_out,
  output wire left_unmute_out,
  output wire left_power_up_out,
  output wire left_gain_pending_out
);

  localparam integer STEP_LAST = STEP_CYCLES - 1;

  reg [11:0] route_en_q;
  reg [6:0] route_vol_q [0:11];
  reg [6:0] appl_vol_q [0:11];
  reg [3:0] level_q [0:1];
  reg [3:0] appl_level_q [0:1];
  reg [1:0] unmute_q;
  reg [1:0] rsvd_q;
  reg [1:0] pwr_q;
  reg [1:0] pend_q;
  reg [1:0] pend_d;
  reg [15:0] div_q;
  reg tick_q;
  reg [7:0] rdata_d;
  wire [3:0] widx;
  wire [3:0] ridx;
  wire [1:0] wlvl;
  wire [1:0] rlvl;
  wire wr_route;
  wire wr_level;
  wire div_wrap;
  reg [1:0] route_diff;
  reg [1:0] level_diff;
  integer i;
  integer j;
  integer k;
  integer m;
  integer n;
  genvar g;

  // route index from address, mono 0..5 and left 6..11
  function [3:0] route_idx;
    input [7:0] addr;
    begin
      case (addr)
        `LOMC_MONO_LINE2_LEFT: route_idx = 4'h0;
        `LOMC_MONO_PGA_LEFT: route_idx = 4'h1;
        `LOMC_MONO_DAC_LEFT_ONE: route_idx = 4'h2;
        `LOMC_MONO_LINE2_RIGHT: route_idx = 4'h3;
        `LOMC_MONO_PGA_RIGHT: route_idx = 4'h4;
        `LOMC_MONO_DAC_RIGHT_ONE: route_idx = 4'h5;
        `LOMC_LEFT_LINE2_LEFT: route_idx = 4'h6;
        `LOMC_LEFT_PGA_LEFT: route_idx = 4'h7;
        `LOMC_LEFT_DAC_LEFT_ONE: route_idx = 4'h8;
        `LOMC_LEFT_LINE2_RIGHT: route_idx = 4'h9;
        `LOMC_LEFT_PGA_RIGHT: route_idx = 4'ha;
        `LOMC_LEFT_DAC_RIGHT_ONE: route_idx = 4'hb;
        default: route_idx = `LOMC_ROUTE_NONE;
      endcase
    end
  endfunction

  // level register select: valid bit, then output (0 mono, 1 left)
  function [1:0] level_sel;
    input [7:0] addr;
    begin
      case (addr)
        `LOMC_MONO_LEVEL: level_sel = 2'h2;
        `LOMC_LEFT_LEVEL: level_sel = 2'h3;
        default: level_sel = 2'h0;
      endcase
    end
  endfunction

  // move an applied volume one code toward its target
  function [6:0] step_vol;
    input [6:0] cur;
    input [6:0] tgt;
    begin
      if (cur < tgt) begin
        step_vol = cur + 7'h01;
      end else if (cur > tgt) begin
        step_vol = cur - 7'h01;
      end else begin
        step_vol = cur;
      end
    end
  endfunction

  // move an applied level one dB toward its target
  function [3:0] step_lvl;
    input [3:0] cur;
    input [3:0] tgt;
    begin
      if (cur < tgt) begin
        step_lvl = cur + 4'h1;
      end else if (cur > tgt) begin
        step_lvl = cur - 4'h1;
      end else begin
        step_lvl = cur;
      end
    end
  endfunction

  assign widx = route_idx(reg_addr_in);
  assign ridx = route_idx(reg_addr_in);
  assign wlvl = level_sel(reg_addr_in);
  assign rlvl = level_sel(reg_addr_in);

  // write decode
  assign wr_route = reg_wr_in && (widx != `LOMC_ROUTE_NONE);
  assign wr_level = reg_wr_in && wlvl[1];
  assign div_wrap = ({16'h0000, div_q} == STEP_LAST);

  // gain step divider, free running from reset
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_q <= 16'h0000;
    end else if (div_wrap) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // one-cycle step tick, registered, in the cycle after the divider wraps
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= div_wrap;
    end
  end

  // a route or level differs from its programmed value while stepping
  always @* begin
    route_diff = 2'b00;
    level_diff = 2'b00;
    for (m = 0; m < 6; m = m + 1) begin
      if (appl_vol_q[m] != route_vol_q[m]) begin
        route_diff[0] = 1'b1;
      end
      if (appl_vol_q[m + 6] != route_vol_q[m + 6]) begin
        route_diff[1] = 1'b1;
      end
    end
    for (m = 0; m < 2; m = m + 1) begin
      if (appl_level_q[m] != level_q[m]) begin
        level_diff[m] = 1'b1;
      end
    end
  end

  // pending per output, mono bit 0 and left bit 1
  always @* begin
    pend_d = route_diff | level_diff;
  end

  // route registers: enable and programmed volume
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      route_en_q <= 12'h000;
      for (i = 0; i < 12; i = i + 1) begin
        route_vol_q[i] <= `LOMC_VOL_RST;
      end
    end else if (wr_route) begin
      route_en_q[widx] <= reg_wdata_in[`LOMC_ROUTE_EN_BIT];
      route_vol_q[widx] <= reg_wdata_in[`LOMC_VOL_MSB:`LOMC_VOL_LSB];
    end
  end

  // level registers; bit 1 has no storage, so a write to it is lost
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (j = 0; j < 2; j = j + 1) begin
        level_q[j] <= `LOMC_LEVEL_RST;
      end
      unmute_q <= 2'b00;
      rsvd_q <= 2'b00;
      pwr_q <= 2'b00;
    end else if (wr_level) begin
      level_q[wlvl[0]] <= reg_wdata_in[`LOMC_LEVEL_MSB:`LOMC_LEVEL_LSB];
      unmute_q[wlvl[0]] <= reg_wdata_in[`LOMC_UNMUTE_BIT];
      rsvd_q[wlvl[0]] <= reg_wdata_in[`LOMC_RSVD_BIT];
      pwr_q[wlvl[0]] <= reg_wdata_in[`LOMC_PWR_BIT];
    end
  end

  // applied volumes walk one code per tick so the analog path never jumps
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (k = 0; k < 12; k = k + 1) begin
        appl_vol_q[k] <= `LOMC_VOL_RST;
      end
    end else if (tick_q) begin
      for (k = 0; k < 12; k = k + 1) begin
        appl_vol_q[k] <= step_vol(appl_vol_q[k], route_vol_q[k]);
      end
    end
  end

  // applied levels walk one dB per tick
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (n = 0; n < 2; n = n + 1) begin
        appl_level_q[n] <= `LOMC_LEVEL_RST;
      end
    end else if (tick_q) begin
      for (n = 0; n < 2; n = n + 1) begin
        appl_level_q[n] <= step_lvl(appl_level_q[n], level_q[n]);
      end
    end
  end

  // pending status, registered
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_q <= 2'b00;
    end else begin
      pend_q <= pend_d;
    end
  end

  // read data, valid only in the cycle after the read strobe
  always @* begin
    rdata_d = 8'h00;
    if (ridx != `LOMC_ROUTE_NONE) begin
      rdata_d = {route_en_q[ridx], route_vol_q[ridx]};
    end else if (rlvl[1]) begin
      rdata_d = {level_q[rlvl[0]], unmute_q[rlvl[0]], rsvd_q[rlvl[0]],
                 pend_q[rlvl[0]], pwr_q[rlvl[0]]};
    end
  end

  // read data register, back to zero when no read
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_d;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // control outputs straight from the flops
  generate
    for (g = 0; g < 6; g = g + 1) begin : gen_vol
      assign mono_route_vol_out[g*7+6:g*7] = appl_vol_q[g];
      assign left_route_vol_out[g*7+6:g*7] = appl_vol_q[g+6];
    end
  endgenerate

  // mono line output
  assign mono_route_en_out = route_en_q[5:0];
  assign mono_level_out = appl_level_q[0];
  assign mono_unmute_out = unmute_q[0];
  assign mono_power_up_out = pwr_q[0];
  assign mono_gain_pending_out = pend_q[0];

  // left line output
  assign left_route_en_out = route_en_q[11:6];
  assign left_level_out = appl_level_q[1];
  assign left_unmute_out = unmute_q[1];
  assign left_power_up_out = pwr_q[1];
  assign left_gain_pending_out = pend_q[1];

endmodule

`default_nettype wire

// ---- dv/lomc_line_out_regs_properties.sv ----
// port assertions for the line output mixer register bank
`default_nettype none
module lomc_line_out_regs_properties (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // controls
  input wire logic [5:0] mono_route_en_out,
  input wire logic mono_unmute_out,
  input wire logic mono_gain_pending_out,
  input wire logic [5:0] left_route_en_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_wr(a);
    reg_wr_in && reg_addr_in == a;
  endsequence
  sequence s_rd(a);
    reg_rd_in && reg_addr_in == a;
  endsequence
  property p_rd_idle; !reg_rd_in |=> reg_rdata_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_en74; s_wr(8'h4a) |=> mono_route_en_out[1] == $past(reg_wdata_in[7]); endproperty
  a_en74: assert property (p_en74) else $error("route enable 74");
  property p_en73; s_wr(8'h49) |=> mono_route_en_out[0] == $past(reg_wdata_in[7]); endproperty
  a_en73: assert property (p_en73) else $error("route enable 73");
  property p_en85; s_wr(8'h55) |=> left_route_en_out[5] == $past(reg_wdata_in[7]); endproperty
  a_en85: assert property (p_en85) else $error("route enable 85");
  property p_hold;
    !(reg_wr_in && reg_addr_in == 8'h4a) |=> $stable(mono_route_en_out[1]);
  endproperty
  a_hold: assert property (p_hold) else $error("route enable moved");
  property p_mute; s_wr(8'h4f) |=> mono_unmute_out == $past(reg_wdata_in[3]); endproperty
  a_mute: assert property (p_mute) else $error("unmute wrong");
  property p_vol;
    s_wr(8'h4b) ##1 !reg_wr_in ##1 s_rd(8'h4b) |=> reg_rdata_out == $past(reg_wdata_in, 3);
  endproperty
  a_vol: assert property (p_vol) else $error("route readback");
  property p_pend; $rose(mono_gain_pending_out) |-> ##[1:1000] !mono_gain_pending_out; endproperty
  a_pend: assert property (p_pend) else $error("gains never applied");
endmodule
bind lomc_line_out_regs lomc_line_out_regs_properties u_props (.sys_clk_in, .rst_n_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .mono_route_en_out,
  .mono_unmute_out, .mono_gain_pending_out, .left_route_en_out);
`default_nettype wire

// ---- dv/lomc_host_model.sv ----
// host controller model on the register port
`default_nettype none
module lomc_host_model (
  // clock
  input wire logic clk_in,
  // register port
  output logic [7:0] addr_out = 8'h00,
  output logic [7:0] wdata_out = 8'h00,
  output logic wr_out = 1'b0,
  output logic rd_out = 1'b0,
  input wire logic [7:0] rdata_in
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h4f || a == 8'h56) begin
      d[7:4] = (d[7:4] > 4'h9) ? 4'h9 : d[7:4];
      d[2] = 1'b0;
    end
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    addr_out <= ~a;
    wdata_out <= ~d;
    wr_out <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    addr_out <= ~a;
    rd_out <= 1'b0;
    #1;
    q = rdata_in;
  endtask
endmodule
`default_nettype wire

// ---- dv/lomc_line_out_regs_tb_top.sv ----
// self-checking bench for the line output mixer register bank
`default_nettype none
module lomc_line_out_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr, wdata, rdata, q;
  logic wr, rd, m_unm, m_pwr, m_pend;
  logic [5:0] m_en, l_en;
  logic [41:0] m_vol;
  logic [3:0] m_lvl;
  logic l_unm, l_pwr, l_pend;
  logic [41:0] l_vol;
  logic [3:0] l_lvl;
  int miscompares = 0;
  int compares = 0;
  initial begin
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  lomc_host_model host (.clk_in(sys_clk_in), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd), .rdata_in(rdata));
  lomc_line_out_regs #(.STEP_CYCLES(4)) dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .mono_route_en_out(m_en), .mono_route_vol_out(m_vol),
    .mono_level_out(m_lvl), .mono_unmute_out(m_unm), .mono_power_up_out(m_pwr),
    .mono_gain_pending_out(m_pend), .left_route_en_out(l_en), .left_route_vol_out(l_vol),
    .left_level_out(l_lvl), .left_unmute_out(l_unm), .left_power_up_out(l_pwr),
    .left_gain_pending_out(l_pend));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_pend(input logic v);
    for (int n = 0; n < 1000 && m_pend !== v; n++) begin
      @(posedge sys_clk_in);
      #1;
    end
    chk({7'h00, m_pend}, {7'h00, v});
  endtask
  task automatic t_midreset;
    @(posedge sys_clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    #1;
    chk({m_en, m_unm, m_pwr}, 8'h00);
    chk({l_lvl, m_lvl}, 8'h00);
    @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_reset();
  endtask
  task automatic t_reset;
    for (int a = 8'h48; a <= 8'h57; a++) begin
      host.rd(a[7:0], q);
      chk(q, 8'h00);
    end
  endtask
  task automatic t_routes;
    for (int a = 8'h49; a <= 8'h57; a++) begin
      host.wr(a[7:0], {1'b1, a[6:0]});
      host.rd(a[7:0], q);
      if (a < 8'h4f || (a > 8'h4f && a < 8'h56))
        chk(q, {1'b1, a[6:0]});
    end
    chk(q, 8'h00);
    chk({m_en, l_en[5:4]}, 8'hff);
    host.wr(8'h4c, 8'h4c);
    host.rd(8'h4c, q);
    chk({2'b00, m_en}, 8'h37);
  endtask
  task automatic t_level;
    wait_pend(1'b0);
    chk({1'b0, m_vol[6:0]}, 8'h49);
    host.wr(8'h4f, 8'h0b);
    host.rd(8'h4f, q);
    chk(q, 8'h0b);
    host.wr(8'h4f, 8'hf6);
    wait_pend(1'b1);
    host.rd(8'h4f, q);
    chk(q, 8'h92);
    wait_pend(1'b0);
    host.rd(8'h4f, q);
    chk(q, 8'h90);
    chk({m_lvl, 2'b00, m_unm, m_pwr}, 8'h90);
    for (int n = 0; n < 1000 && l_pend !== 1'b0; n++) begin
      @(posedge sys_clk_in);
      #1;
    end
    chk({7'h00, l_pend}, 8'h00);
    chk({1'b0, m_vol[41:35]}, 8'h4e);
    chk({1'b0, l_vol[41:35]}, 8'h55);
    chk({l_lvl, 2'b00, l_unm, l_pwr}, 8'h90);
  endtask
  initial begin
    repeat (8) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_routes();
    t_level();
    t_midreset();
    end_sim();
  end
  initial begin
    #40000;
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
